//--- design/lcs_indicators.sv
// Lamp and seven-segment drive for transmitter and receiver status
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Tx first lamp dark off, red on device error, else green.
// - Tx second lamp flashes 10 s on reduced range, else shows channel.
// - Rx first lamp red outputs off; slow red external, fast red internal.
// - Rx first lamp green outputs on; slow green flash on weak signal.
// - Yellow off: interlock disabled, released, or locked with field interrupted.
// - Yellow steady when interlock locked and ready.
// - Yellow flashes on open upstream circuit; 1 or 2 on changeover.
// - Blue off idle, steady when blanking taught, slow flash during muting.
// - Blue short flashes when teaching, muting restart needed, or override.
// - Normal display shows operating mode number one to six.
// - Display rotated half turn in modes 4 and 6, upright otherwise.
// - Power-up shows all segments during self test, then t and response time.
// - Error class letters: F internal, E external, U application usage.
// - Error shows letter then code digits, cycling while error persists.
// - Non-locking error auto recovers after 10 s without restarting outputs.
// - Locking error holds until power is removed.
// - Alignment mode when not aligned or field interrupted about 5 s.
// - Top, middle, bottom segments show upper, middle, lower field thirds.
// - Segment on all clear, flashing some clear, off all interrupted.
// - Field clear about 5 s leaves alignment mode back to mode number.
module lcs_indicators #(
    parameter int unsigned P_SLOW_CYC = lcs_pkg::SLOW_CYC,
    parameter int unsigned P_FAST_CYC = lcs_pkg::FAST_CYC,
    parameter int unsigned P_SHORT_ON_CYC = lcs_pkg::SHORT_ON_CYC,
    parameter int unsigned P_RANGE_FLASH_CYC = lcs_pkg::RANGE_FLASH_CYC,
    parameter int unsigned P_AUTO_RESET_CYC = lcs_pkg::AUTO_RESET_CYC,
    parameter int unsigned P_ALIGN_ENTER_CYC = lcs_pkg::ALIGN_ENTER_CYC,
    parameter int unsigned P_ALIGN_EXIT_CYC = lcs_pkg::ALIGN_EXIT_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_device_error,
    input wire logic i_reduced_range,
    input wire logic i_tx_channel2,
    input wire logic i_safety_switching_outputs_on,
    input wire logic i_external_fault,
    input wire logic i_internal_error,
    input wire logic i_weak_signal,
    input wire logic i_restart_interlock_en,
    input wire logic i_restart_interlock_locked,
    input wire logic i_field_clear,
    input wire logic i_linked_sensor_ok,
    input wire logic i_upstream_open,
    input wire logic i_upstream_changeover,
    input wire logic i_changeover_double,
    input wire logic i_blanking_taught,
    input wire logic i_muting_active,
    input wire logic i_teach_active,
    input wire logic i_muting_restart_req,
    input wire logic i_muting_override,
    input wire logic [2:0] i_op_mode,
    input wire logic i_selftest_done,
    input wire logic [6:0] i_response_time_ms,
    input wire logic i_err_event,
    input wire logic [1:0] i_err_class,
    input wire logic [6:0] i_err_code,
    input wire logic i_err_locking,
    input wire logic i_aligned,
    input wire logic [2:0] i_third_all_clear,
    input wire logic [2:0] i_third_any_clear,
    output logic o_tx_lamp1_red,
    output logic o_tx_lamp1_green,
    output logic o_tx_lamp2_green,
    output logic o_primary_status_lamp_red,
    output logic o_primary_status_lamp_green,
    output logic o_secondary_status_lamp,
    output logic o_function_status_lamp,
    output logic [6:0] o_seg,
    output logic o_error_active,
    output logic o_automatic_error_recovery
);
    logic slow_lamp;
    logic slow_wrap;
    logic fast_lamp;
    logic short_lamp;
    lcs_pkg::lcs_pwr_t pwr_q;
    lcs_pkg::lcs_err_t err_class_q;
    logic [6:0] err_code_q;
    logic err_lock_q;
    logic [1:0] sym_q;
    logic [1:0] flash_left_q;
    logic align_q;
    logic err_new;
    logic err_clear;
    logic ready;
    logic rot;
    logic tx1r_d;
    logic tx2_d;
    logic rxr_d;
    logic rxg_d;
    logic yel_d;
    logic blue_d;
    logic [6:0] seg_d;
    logic [6:0] base;
    logic [6:0] num;
    logic [3:0] tens;
    logic [3:0] units;

    lcs_tmr_if range_if ();
    lcs_tmr_if auto_if ();
    lcs_tmr_if enter_if ();
    lcs_tmr_if exit_if ();

    lcs_blinker #(.PERIOD(P_SLOW_CYC), .ON(P_SLOW_CYC / 2)) u_slow (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .o_lamp(slow_lamp),
        .o_wrap(slow_wrap)
    );
    lcs_blinker #(.PERIOD(P_FAST_CYC), .ON(P_FAST_CYC / 2)) u_fast (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .o_lamp(fast_lamp),
        .o_wrap()
    );
    lcs_blinker #(.PERIOD(P_SLOW_CYC), .ON(P_SHORT_ON_CYC)) u_short (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .o_lamp(short_lamp),
        .o_wrap()
    );
    lcs_timer #(.CYCLES(P_RANGE_FLASH_CYC)) u_range (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .bus(range_if.tmr)
    );
    lcs_timer #(.CYCLES(P_AUTO_RESET_CYC)) u_auto (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .bus(auto_if.tmr)
    );
    lcs_timer #(.CYCLES(P_ALIGN_ENTER_CYC)) u_enter (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .bus(enter_if.tmr)
    );
    lcs_timer #(.CYCLES(P_ALIGN_EXIT_CYC)) u_exit (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .bus(exit_if.tmr)
    );

    // Range flash window counts from reset release
    assign range_if.run = 1'b1;
    assign auto_if.run = (err_class_q != lcs_pkg::ERR_NONE) && !err_lock_q;
    assign enter_if.run = !i_field_clear;
    assign exit_if.run = i_field_clear && i_aligned;

    // Locked error keeps its cause on show
    assign err_new = i_err_event && !err_lock_q && (i_err_class != 2'h0);
    assign err_clear = auto_if.done && !err_new;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            err_class_q <= lcs_pkg::ERR_NONE;
            err_code_q <= 7'h00;
            err_lock_q <= 1'b0;
        end else if (err_new) begin
            err_class_q <= lcs_pkg::lcs_err_t'(i_err_class);
            err_code_q <= (i_err_code > lcs_pkg::CODE_MAX) ? lcs_pkg::CODE_MAX : i_err_code;
            err_lock_q <= i_err_locking;
        end else if (err_clear) begin
            err_class_q <= lcs_pkg::ERR_NONE;
            err_code_q <= 7'h00;
        end
    end

    // Pulse makes the interlock relock
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_automatic_error_recovery <= 1'b0;
        end else begin
            o_automatic_error_recovery <= err_clear;
        end
    end

    assign o_error_active = (err_class_q != lcs_pkg::ERR_NONE);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pwr_q <= lcs_pkg::PWR_SELFTEST;
        end else begin
            case (pwr_q)
                lcs_pkg::PWR_SELFTEST: begin
                    if (i_selftest_done) begin
                        pwr_q <= lcs_pkg::PWR_RESP;
                    end
                end
                lcs_pkg::PWR_RESP: begin
                    if (slow_wrap && (sym_q == lcs_pkg::SYM_LAST)) begin
                        pwr_q <= lcs_pkg::PWR_RUN;
                    end
                end
                lcs_pkg::PWR_RUN: begin
                    pwr_q <= lcs_pkg::PWR_RUN;
                end
                default: begin
                    pwr_q <= lcs_pkg::PWR_SELFTEST;
                end
            endcase
        end
    end

    // One symbol per slow period
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || err_new || (pwr_q == lcs_pkg::PWR_SELFTEST)) begin
            sym_q <= 2'h0;
        end else if (slow_wrap) begin
            sym_q <= (sym_q == lcs_pkg::SYM_LAST) ? 2'h0 : sym_q + 2'h1;
        end
    end

    // First flash may be short
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            flash_left_q <= 2'h0;
        end else if (i_upstream_changeover) begin
            flash_left_q <= i_changeover_double ? lcs_pkg::FLASH_TWO : lcs_pkg::FLASH_ONE;
        end else if (slow_wrap && (flash_left_q != 2'h0)) begin
            flash_left_q <= flash_left_q - 2'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            align_q <= 1'b0;
        end else if (!i_aligned || enter_if.done) begin
            align_q <= 1'b1;
        end else if (exit_if.done) begin
            align_q <= 1'b0;
        end
    end

    assign ready = i_restart_interlock_en && i_restart_interlock_locked && i_field_clear && i_linked_sensor_ok;
    assign rot = (i_op_mode == 3'h4) || (i_op_mode == 3'h6);
    assign num = (pwr_q == lcs_pkg::PWR_RESP) ? i_response_time_ms : err_code_q;
    assign tens = 4'(num / 7'h0a);
    assign units = 4'(num % 7'h0a);

    always_comb begin
        tx1r_d = i_device_error;
        tx2_d = (i_reduced_range && !range_if.done) ? slow_lamp : i_tx_channel2;
        rxr_d = 1'b0;
        rxg_d = 1'b0;
        if (i_internal_error) begin
            rxr_d = fast_lamp;
        end else if (i_external_fault) begin
            rxr_d = slow_lamp;
        end else if (i_safety_switching_outputs_on) begin
            rxg_d = i_weak_signal ? slow_lamp : 1'b1;
        end else begin
            rxr_d = 1'b1;
        end
        if (i_upstream_open) begin
            yel_d = slow_lamp;
        end else if (flash_left_q != 2'h0) begin
            yel_d = slow_lamp;
        end else begin
            yel_d = ready;
        end
        if (i_teach_active || i_muting_restart_req || i_muting_override) begin
            blue_d = short_lamp;
        end else if (i_muting_active) begin
            blue_d = slow_lamp;
        end else begin
            blue_d = i_blanking_taught;
        end
    end

    always_comb begin
        base = lcs_pkg::SEG_BLANK;
        case (pwr_q)
            lcs_pkg::PWR_SELFTEST: begin
                base = lcs_pkg::SEG_ALL;
            end
            lcs_pkg::PWR_RESP: begin
                case (sym_q)
                    2'h0: base = lcs_pkg::SEG_T;
                    2'h1: base = lcs_pkg::lcs_digit(tens);
                    default: base = lcs_pkg::lcs_digit(units);
                endcase
            end
            lcs_pkg::PWR_RUN: begin
                if (err_class_q != lcs_pkg::ERR_NONE) begin
                    case (sym_q)
                        2'h0: begin
                            case (err_class_q)
                                lcs_pkg::ERR_FAIL: base = lcs_pkg::SEG_F;
                                lcs_pkg::ERR_EXT: base = lcs_pkg::SEG_E;
                                default: base = lcs_pkg::SEG_U;
                            endcase
                        end
                        2'h1: base = lcs_pkg::lcs_digit(tens);
                        default: base = lcs_pkg::lcs_digit(units);
                    endcase
                end else if (align_q) begin
                    base[lcs_pkg::SEG_A] = i_third_all_clear[0] | (i_third_any_clear[0] & slow_lamp);
                    base[lcs_pkg::SEG_G] = i_third_all_clear[1] | (i_third_any_clear[1] & slow_lamp);
                    base[lcs_pkg::SEG_D] = i_third_all_clear[2] | (i_third_any_clear[2] & slow_lamp);
                end else begin
                    base = lcs_pkg::lcs_digit({1'b0, i_op_mode});
                end
            end
            default: begin
                base = lcs_pkg::SEG_BLANK;
            end
        endcase
        seg_d = rot ? lcs_pkg::lcs_rot(base) : base;
    end

    // Dark in reset, as unpowered
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_tx_lamp1_red <= 1'b0;
            o_tx_lamp1_green <= 1'b0;
            o_tx_lamp2_green <= 1'b0;
            o_primary_status_lamp_red <= 1'b0;
            o_primary_status_lamp_green <= 1'b0;
            o_secondary_status_lamp <= 1'b0;
            o_function_status_lamp <= 1'b0;
            o_seg <= lcs_pkg::SEG_BLANK;
        end else begin
            o_tx_lamp1_red <= tx1r_d;
            o_tx_lamp1_green <= !tx1r_d;
            o_tx_lamp2_green <= tx2_d;
            o_primary_status_lamp_red <= rxr_d;
            o_primary_status_lamp_green <= rxg_d;
            o_secondary_status_lamp <= yel_d;
            o_function_status_lamp <= blue_d;
            o_seg <= seg_d;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    a_tx_red_error: assert property (i_device_error |=> o_tx_lamp1_red && !o_tx_lamp1_green)
        else $error("tx not red");
    a_rx_red_off: assert property ((!i_safety_switching_outputs_on && !i_internal_error && !i_external_fault)
        |=> o_primary_status_lamp_red && !o_primary_status_lamp_green)
        else $error("rx not red");
    a_rx_green_on: assert property ((i_safety_switching_outputs_on && !i_weak_signal && !i_internal_error
        && !i_external_fault) |=> o_primary_status_lamp_green && !o_primary_status_lamp_red)
        else $error("rx not green");
    a_yellow_ready: assert property ((ready && !i_upstream_open && flash_left_q == 2'h0 && !i_upstream_changeover)
        |=> o_secondary_status_lamp)
        else $error("yellow dark");
    a_yellow_idle: assert property ((!i_restart_interlock_en && !i_upstream_open && flash_left_q == 2'h0)
        |=> !o_secondary_status_lamp)
        else $error("yellow lit");
    a_blue_taught: assert property ((i_blanking_taught && !i_muting_active && !i_teach_active
        && !i_muting_restart_req && !i_muting_override) |=> o_function_status_lamp)
        else $error("blue dark");
    a_selftest_all: assert property ((pwr_q == lcs_pkg::PWR_SELFTEST) |=> o_seg == lcs_pkg::SEG_ALL)
        else $error("self test wrong");
    a_lock_holds: assert property (err_lock_q |=> err_lock_q && !o_automatic_error_recovery)
        else $error("lock released");
    a_recovery_cause: assert property (o_automatic_error_recovery |-> $past(auto_if.done) && !$past(err_lock_q))
        else $error("bad recovery");
    a_err_letter: assert property ((pwr_q == lcs_pkg::PWR_RUN && err_class_q == lcs_pkg::ERR_FAIL
        && sym_q == 2'h0 && !rot) |=> o_seg == lcs_pkg::SEG_F)
        else $error("no letter");
    a_mode_rotated: assert property ((pwr_q == lcs_pkg::PWR_RUN && err_class_q == lcs_pkg::ERR_NONE && !align_q
        && i_op_mode == 3'h4) |=> o_seg == lcs_pkg::lcs_rot(lcs_pkg::lcs_digit(4'h4)))
        else $error("not rotated");

    c_recovery: cover property (o_automatic_error_recovery);
    c_align: cover property ($rose(align_q));
    c_resp_done: cover property (pwr_q == lcs_pkg::PWR_RESP ##1 pwr_q == lcs_pkg::PWR_RUN);
    c_double_flash: cover property (i_upstream_changeover && i_changeover_double);
endmodule // lcs_indicators
`default_nettype wire

//--- design/lcs_pkg.sv
// Constants, types and segment helpers for the light curtain status indicators
package lcs_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned SLOW_PERIOD_MS = 1000;
    localparam int unsigned FAST_PERIOD_MS = 100;
    localparam int unsigned SHORT_ON_MS = 100;
    localparam int unsigned RANGE_FLASH_MS = 10000;
    localparam int unsigned AUTO_RESET_MS = 10000;
    localparam int unsigned ALIGN_ENTER_MS = 5000;
    localparam int unsigned ALIGN_EXIT_MS = 5000;
    localparam int unsigned SLOW_CYC = CYC_PER_MS * SLOW_PERIOD_MS;
    localparam int unsigned FAST_CYC = CYC_PER_MS * FAST_PERIOD_MS;
    localparam int unsigned SHORT_ON_CYC = CYC_PER_MS * SHORT_ON_MS;
    localparam int unsigned RANGE_FLASH_CYC = CYC_PER_MS * RANGE_FLASH_MS;
    localparam int unsigned AUTO_RESET_CYC = CYC_PER_MS * AUTO_RESET_MS;
    localparam int unsigned ALIGN_ENTER_CYC = CYC_PER_MS * ALIGN_ENTER_MS;
    localparam int unsigned ALIGN_EXIT_CYC = CYC_PER_MS * ALIGN_EXIT_MS;
    localparam int unsigned CNT_W = 32;
    localparam logic [1:0] SYM_LAST = 2'h2;
    localparam logic [1:0] FLASH_ONE = 2'h1;
    localparam logic [1:0] FLASH_TWO = 2'h2;
    localparam logic [6:0] CODE_MAX = 7'h63;
    localparam int unsigned SEG_A = 0;
    localparam int unsigned SEG_D = 3;
    localparam int unsigned SEG_G = 6;
    localparam logic [6:0] SEG_ALL = 7'h7f;
    localparam logic [6:0] SEG_BLANK = 7'h00;
    localparam logic [6:0] SEG_T = 7'h78;
    localparam logic [6:0] SEG_F = 7'h71;
    localparam logic [6:0] SEG_E = 7'h79;
    localparam logic [6:0] SEG_U = 7'h3e;
    typedef enum logic [1:0] {
        PWR_SELFTEST = 2'b00,
        PWR_RESP = 2'b01,
        PWR_RUN = 2'b10
    } lcs_pwr_t;
    typedef enum logic [1:0] {
        ERR_NONE = 2'b00,
        ERR_FAIL = 2'b01,
        ERR_EXT = 2'b10,
        ERR_USE = 2'b11
    } lcs_err_t;
    // Bit order g f e d c b a
    function automatic logic [6:0] lcs_digit(input logic [3:0] d);
        case (d)
            4'h0: return 7'h3f;
            4'h1: return 7'h06;
            4'h2: return 7'h5b;
            4'h3: return 7'h4f;
            4'h4: return 7'h66;
            4'h5: return 7'h6d;
            4'h6: return 7'h7d;
            4'h7: return 7'h07;
            4'h8: return 7'h7f;
            4'h9: return 7'h6f;
            default: return SEG_BLANK;
        endcase
    endfunction
    // Half turn swaps a-d, b-e, c-f
    function automatic logic [6:0] lcs_rot(input logic [6:0] s);
        return {s[6], s[2], s[1], s[0], s[5], s[4], s[3]};
    endfunction
endpackage

//--- design/lcs_tmr_if.sv
// Run and expiry pair for a timeout counter
`timescale 1ns/10ps
`default_nettype none
interface lcs_tmr_if;
    logic run;
    logic done;
    modport ctl (output run, input done);
    modport tmr (input run, output done);
endinterface
`default_nettype wire

//--- design/lcs_timer.sv
// Timeout counter
`timescale 1ns/10ps
`default_nettype none
module lcs_timer #(
    parameter int unsigned CYCLES = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    lcs_tmr_if.tmr bus
);
    logic [lcs_pkg::CNT_W-1:0] cnt_q;

    // Any gap in run restarts the count
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !bus.run) begin
            cnt_q <= '0;
        end else if (cnt_q != lcs_pkg::CNT_W'(CYCLES)) begin
            cnt_q <= cnt_q + lcs_pkg::CNT_W'(1);
        end
    end

    assign bus.done = (cnt_q == lcs_pkg::CNT_W'(CYCLES));
endmodule // lcs_timer
`default_nettype wire

//--- design/lcs_blinker.sv
// Free running flash generator
`timescale 1ns/10ps
`default_nettype none
module lcs_blinker #(
    parameter int unsigned PERIOD = 2,
    parameter int unsigned ON = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    output logic o_lamp,
    output logic o_wrap
);
    logic [lcs_pkg::CNT_W-1:0] cnt_q;
    logic last;

    assign last = (cnt_q == lcs_pkg::CNT_W'(PERIOD - 1));

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || last) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + lcs_pkg::CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_lamp <= 1'b0;
            o_wrap <= 1'b0;
        end else begin
            o_lamp <= last || (cnt_q < lcs_pkg::CNT_W'(ON - 1));
            o_wrap <= last;
        end
    end
endmodule // lcs_blinker
`default_nettype wire

//--- tb/lcs_panel_model.sv
// Operator panel model: counts lit transitions of one selected lamp
`timescale 1ns/10ps
`default_nettype none
module lcs_panel_model (
    input wire logic i_clk_sys,
    input wire logic i_clr,
    input wire logic [7:0] i_lamps,
    input wire logic [2:0] i_sel,
    output logic [7:0] o_rises
);
    logic [7:0] prev_q;
    // Eye sees flashes, so count rises
    always_ff @(posedge i_clk_sys) begin
        prev_q <= i_lamps;
        if (i_clr) o_rises <= 8'h00;
        else if (i_lamps[i_sel] && !prev_q[i_sel]) o_rises <= o_rises + 8'h01;
    end
endmodule // lcs_panel_model
`default_nettype wire

//--- tb/lcs_indicators_tb_top.sv
// Self-checking bench for the status indicator block
`timescale 1ns/10ps
`default_nettype none
module lcs_indicators_tb_top;
    logic i_clk_sys = 1'b0, i_srst = 1'b1, i_device_error = 1'b0, i_reduced_range = 1'b1, i_tx_channel2 = 1'b1;
    logic i_safety_switching_outputs_on = 1'b0, i_external_fault = 1'b0, i_internal_error = 1'b0, i_weak_signal = 1'b0;
    logic i_restart_interlock_en = 1'b0, i_restart_interlock_locked = 1'b0, i_field_clear = 1'b1, i_linked_sensor_ok = 1'b1;
    logic i_upstream_open = 1'b0, i_upstream_changeover = 1'b0, i_changeover_double = 1'b0, i_blanking_taught = 1'b0;
    logic i_muting_active = 1'b0, i_teach_active = 1'b0, i_muting_restart_req = 1'b0, i_muting_override = 1'b0;
    logic i_selftest_done = 1'b0, i_err_event = 1'b0, i_err_locking = 1'b0, i_aligned = 1'b1, clr = 1'b0;
    logic [2:0] i_op_mode = 3'h1, i_third_all_clear = 3'h7, i_third_any_clear = 3'h7, sel = 3'h0;
    logic [6:0] i_response_time_ms = 7'h2a, i_err_code = 7'h07, o_seg;
    logic [1:0] i_err_class = 2'h0;
    logic o_tx_lamp1_red, o_tx_lamp1_green, o_tx_lamp2_green, o_primary_status_lamp_red, o_primary_status_lamp_green;
    logic o_secondary_status_lamp, o_function_status_lamp, o_error_active, o_automatic_error_recovery;
    logic [7:0] rises;
    int fails = 0, tests_run = 0;
    lcs_indicators #(.P_SLOW_CYC(20), .P_FAST_CYC(4), .P_SHORT_ON_CYC(3), .P_RANGE_FLASH_CYC(50),
        .P_AUTO_RESET_CYC(60), .P_ALIGN_ENTER_CYC(30), .P_ALIGN_EXIT_CYC(30)) i_lcs_indicators (.*);
    lcs_panel_model i_lcs_panel_model (.i_clk_sys(i_clk_sys), .i_clr(clr), .i_sel(sel), .o_rises(rises),
        .i_lamps({o_seg[6], o_function_status_lamp, o_secondary_status_lamp, o_primary_status_lamp_green,
        o_primary_status_lamp_red, o_tx_lamp2_green, o_tx_lamp1_green, o_tx_lamp1_red}));
    always #2.5 i_clk_sys = ~i_clk_sys;
    task automatic finish_test();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        tests_run++;
        if (!ok) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic wait_seg(input logic [6:0] mk, input logic [6:0] v, input int n, input string m);
        for (int k = 0; k < n && (o_seg & mk) !== v; k++) @(negedge i_clk_sys);
        chk((o_seg & mk) === v, m);
        if ((o_seg & mk) !== v) finish_test();
    endtask
    task automatic rate(input logic [2:0] s, input int lo, input int hi, input string m);
        @(posedge i_clk_sys);
        sel <= s;
        clr <= 1'b1;
        @(posedge i_clk_sys);
        clr <= 1'b0;
        repeat (40) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk(rises >= lo && rises <= hi, m);
    endtask
    task automatic power_cycle();
        @(posedge i_clk_sys);
        i_srst <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        repeat (2) @(negedge i_clk_sys);
    endtask
    task automatic pulse_err(input logic [1:0] c, input logic lk);
        @(posedge i_clk_sys);
        i_err_event <= 1'b1;
        i_err_class <= c;
        i_err_locking <= lk;
        @(posedge i_clk_sys);
        i_err_event <= 1'b0;
        @(negedge i_clk_sys);
    endtask
    task automatic wait_rec();
        for (int k = 0; k < 70 && o_automatic_error_recovery !== 1'b1; k++) @(negedge i_clk_sys);
        chk(o_automatic_error_recovery === 1'b1 && o_error_active === 1'b0, "recovery");
    endtask
    task automatic t_power();
        chk(o_seg === 7'h7f, "self test");
        rate(3'h2, 1, 2, "range flash");
        repeat (20) @(negedge i_clk_sys);
        chk(o_tx_lamp2_green === 1'b1, "channel two");
        @(posedge i_clk_sys);
        i_selftest_done <= 1'b1;
        wait_seg(7'h7f, 7'h78, 25, "t");
        wait_seg(7'h7f, 7'h66, 25, "tens");
        wait_seg(7'h7f, 7'h5b, 25, "units");
        wait_seg(7'h7f, 7'h06, 25, "mode");
    endtask
    task automatic t_lamps();
        @(posedge i_clk_sys);
        i_device_error <= 1'b1;
        repeat (2) @(negedge i_clk_sys);
        chk(o_tx_lamp1_red === 1'b1 && o_tx_lamp1_green === 1'b0, "tx red");
        chk(o_primary_status_lamp_red === 1'b1 && o_primary_status_lamp_green === 1'b0, "rx red");
        i_external_fault <= 1'b1;
        rate(3'h3, 1, 2, "slow red");
        i_internal_error <= 1'b1;
        rate(3'h3, 9, 10, "fast red");
        i_internal_error <= 1'b0;
        i_external_fault <= 1'b0;
        i_device_error <= 1'b0;
        i_safety_switching_outputs_on <= 1'b1;
        i_weak_signal <= 1'b1;
        rate(3'h4, 1, 2, "weak green");
        i_weak_signal <= 1'b0;
        rate(3'h4, 0, 0, "green");
        chk(o_primary_status_lamp_green === 1'b1 && o_tx_lamp1_green === 1'b1, "steady green");
    endtask
    task automatic t_yellow();
        i_restart_interlock_en <= 1'b1;
        i_restart_interlock_locked <= 1'b1;
        rate(3'h5, 0, 0, "ready flat");
        chk(o_secondary_status_lamp === 1'b1, "ready");
        i_linked_sensor_ok <= 1'b0;
        repeat (2) @(negedge i_clk_sys);
        chk(o_secondary_status_lamp === 1'b0, "linked off");
        i_linked_sensor_ok <= 1'b1;
        i_field_clear <= 1'b0;
        repeat (2) @(negedge i_clk_sys);
        chk(o_secondary_status_lamp === 1'b0, "field off");
        i_field_clear <= 1'b1;
        i_upstream_open <= 1'b1;
        rate(3'h5, 1, 2, "upstream");
        i_upstream_open <= 1'b0;
        i_restart_interlock_locked <= 1'b0;
        i_upstream_changeover <= 1'b1;
        i_changeover_double <= 1'b1;
        @(posedge i_clk_sys);
        i_upstream_changeover <= 1'b0;
        rate(3'h5, 1, 2, "changeover");
        rate(3'h5, 0, 0, "released");
        chk(o_secondary_status_lamp === 1'b0, "released off");
    endtask
    task automatic t_blue();
        i_blanking_taught <= 1'b1;
        rate(3'h6, 0, 0, "taught flat");
        chk(o_function_status_lamp === 1'b1, "taught");
        i_muting_active <= 1'b1;
        rate(3'h6, 1, 2, "muting");
        for (int k = 0; k < 3; k++) begin
            {i_teach_active, i_muting_restart_req, i_muting_override} <= 3'h1 << k;
            rate(3'h6, 1, 2, "short flash");
        end
    endtask
    task automatic t_modes();
        logic [6:0] d [1:6] = '{7'h06, 7'h5b, 7'h4f, 7'h74, 7'h6d, 7'h6f};
        for (int k = 6; k >= 2; k--) begin
            i_op_mode <= k[2:0];
            repeat (2) @(negedge i_clk_sys);
            chk(o_seg === d[k], "mode digit");
        end
    endtask
    task automatic t_align();
        i_field_clear <= 1'b0;
        i_third_all_clear <= 3'h1;
        i_third_any_clear <= 3'h3;
        repeat (20) @(negedge i_clk_sys);
        chk(o_seg === 7'h5b, "early");
        wait_seg(7'h3f, 7'h01, 20, "align");
        rate(3'h7, 1, 2, "middle");
        pulse_err(2'h2, 1'b0);
        wait_seg(7'h7f, 7'h79, 3, "err first");
        wait_rec();
        wait_seg(7'h3f, 7'h01, 5, "align back");
        i_field_clear <= 1'b1;
        i_third_all_clear <= 3'h7;
        repeat (20) @(negedge i_clk_sys);
        chk(o_seg === 7'h49, "all on");
        wait_seg(7'h7f, 7'h5b, 20, "leave");
    endtask
    task automatic t_errors();
        logic [6:0] lt [1:3] = '{7'h71, 7'h79, 7'h3e};
        for (int k = 1; k <= 3; k++) begin
            pulse_err(k[1:0], 1'b0);
            chk(o_error_active === 1'b1, "active");
            wait_seg(7'h7f, lt[k], 3, "letter");
            wait_seg(7'h7f, 7'h3f, 25, "code tens");
            wait_seg(7'h7f, 7'h07, 25, "code units");
            wait_rec();
        end
        pulse_err(2'h1, 1'b1);
        wait_seg(7'h7f, 7'h07, 45, "lock units");
        wait_seg(7'h7f, 7'h71, 25, "again");
        pulse_err(2'h3, 1'b0);
        repeat (70) @(negedge i_clk_sys);
        chk(o_error_active === 1'b1 && o_seg !== 7'h3e, "locked");
        i_selftest_done <= 1'b0;
        i_reduced_range <= 1'b0;
        i_tx_channel2 <= 1'b0;
        power_cycle();
        chk(o_seg === 7'h7f && o_error_active === 1'b0, "power off");
        chk(o_tx_lamp2_green === 1'b0, "channel one");
        i_selftest_done <= 1'b1;
        wait_seg(7'h7f, 7'h5b, 90, "restart");
    endtask
    initial begin
        power_cycle();
        t_power();
        t_lamps();
        t_yellow();
        t_blue();
        t_modes();
        t_align();
        t_errors();
        finish_test();
    end
endmodule // lcs_indicators_tb_top
`default_nettype wire
